// >>> rtl/fepc_regs.svh
// fepc_regs.svh: opcodes, field positions and timing constants for the erase/program sequencer
// assumes it is included by bare name from the sequencer, its only user
`ifndef FEPC_REGS_SVH
`define FEPC_REGS_SVH

// command opcodes
`define FEPC_OP_UNLOCK     8'h06
`define FEPC_OP_SMALL      8'h20
`define FEPC_OP_HALF       8'h52
`define FEPC_OP_FULL       8'hD8
`define FEPC_OP_ARRAY      8'h60
`define FEPC_OP_ARRAY_ALT  8'hC7
`define FEPC_OP_PAGE       8'h02
`define FEPC_OP_WIDE_IN    8'hB7
`define FEPC_OP_WIDE_OUT   8'hE9

// address field positions
`define FEPC_ADDR_W        26
`define FEPC_SMALL_LSB     12
`define FEPC_HALF_LSB      15
`define FEPC_FULL_LSB      16
`define FEPC_PAGE_LSB      8
`define FEPC_PAGE_BYTES    256

// self-timed cycle lengths in microseconds, clock rate in MHz
`define FEPC_CLK_MHZ            64'd50
`define FEPC_SMALL_WIPE_US      64'd30000
`define FEPC_HALF_BLOCK_WIPE_US 64'd150000
`define FEPC_FULL_BLOCK_WIPE_US 64'd250000
`define FEPC_ARRAY_WIPE_US      64'd60000000
`define FEPC_PAGE_WRITE_US      64'd600

`endif

// >>> rtl/fepc_pkg.sv
// fepc_pkg.sv: types shared by the erase/program sequencer
// assumes nothing beyond a SystemVerilog compiler
package fepc_pkg;

	// sequencer states
	typedef enum {
		FEPC_ST_IDLE,
		FEPC_ST_WALK_CHIP,
		FEPC_ST_WALK_PAGE,
		FEPC_ST_WAIT
	} fepc_state_type;

	// kind of array operation handed to the cell array
	typedef enum logic [2:0] {
		FEPC_KIND_SMALL,
		FEPC_KIND_HALF,
		FEPC_KIND_FULL,
		FEPC_KIND_ARRAY,
		FEPC_KIND_PAGE
	} fepc_kind_type;

endpackage

// >>> rtl/fepc_flash_seq.sv
// fepc_flash_seq.sv: serial flash erase and page-write command decoder and sequencer
// assumes a host drives chip select, link clock and data lines; cell array sits behind arr* ports
//
// Notes on behaviour
// - wipe or write needs unlock flag set
// - small wipe sets addressed 4K sector
// - sector chosen by address bits above 11
// - wipe rejected unless chip select ends address
// - cycle starts at select rise, clears flags
// - running flag visible through whole cycle
// - wipe refused on guarded block, scheme-dependent
// - half wipe clears 32K block, bits above 14
// - full wipe clears 64K block, any address
// - array wipe ends exactly after opcode
// - scheme 0 array wipe needs guard bits zero
// - scheme 1 array wipe skips guarded blocks
// - page write takes one to 256 bytes
// - only last 256 data bytes kept
// - low address byte is offset, wraps in page
// - page write ends on complete data byte
// - page write refused on guarded block
// - opcode on one line or four lines
// - three address bytes unless wide mode
`timescale 1ns/10ps
`include "fepc_regs.svh"

module fepc_flash_seq
	import fepc_pkg::*;
#(
	parameter int          ADDR_W     = `FEPC_ADDR_W,
	parameter logic [31:0] SMALL_CYC  = 32'(`FEPC_SMALL_WIPE_US * `FEPC_CLK_MHZ),
	parameter logic [31:0] HALF_CYC   = 32'(`FEPC_HALF_BLOCK_WIPE_US * `FEPC_CLK_MHZ),
	parameter logic [31:0] FULL_CYC   = 32'(`FEPC_FULL_BLOCK_WIPE_US * `FEPC_CLK_MHZ),
	parameter logic [31:0] ARRAY_CYC  = 32'(`FEPC_ARRAY_WIPE_US * `FEPC_CLK_MHZ),
	parameter logic [31:0] PAGE_CYC   = 32'(`FEPC_PAGE_WRITE_US * `FEPC_CLK_MHZ)
)(
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  sclkLink,
	input  wire logic                  csLinkN,
	input  wire logic                  serialIn,
	input  wire logic [2:0]            upperIoLines,
	input  wire logic                  quadCmdMode,
	input  wire logic                  guardSchemePick,
	input  wire logic [3:0]            blockGuardBits,
	input  wire logic [(1<<(ADDR_W-16))-1:0] persistentGuardBits,
	input  wire logic [(1<<(ADDR_W-16))-1:0] dynamicGuardBits,
	input  wire logic [31:0]           edgeSectorGuardBits,
	input  wire logic [ADDR_W-25:0]    highAddrBitsReg,
	output logic                       opRunningFlag,
	output logic                       writeUnlockFlag,
	output logic                       cmdRefused,
	output logic                       arrEraseStb,
	output logic [ADDR_W-1:0]          arrEraseBase,
	output fepc_kind_type              arrEraseKind,
	output logic                       arrPgmStb,
	output logic [ADDR_W-1:0]          arrPgmAddr,
	output logic [7:0]                 arrPgmData
);

	localparam int BLK_W = ADDR_W - 16;
	localparam int NBLK  = 1 << BLK_W;

	// the address mux and the block guard table only cover these widths
	if (ADDR_W < 25 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must lie between 25 and 32");
	end
	if (SMALL_CYC == 0 || HALF_CYC == 0 || FULL_CYC == 0 || ARRAY_CYC == 0 || PAGE_CYC == 0)
	begin : g_bad_cyc
		$error("cycle counts must be at least one");
	end

	// ---------------- link domain ----------------
	logic       quadS1_q, quadLk_q, busyS1_q, busyLk_q;
	logic [2:0] bitPos_q, byteCnt_q;
	logic [7:0] shReg_q, opcode_q, startOff_q, dataPtr_q;
	logic [31:0] addr_q;
	logic [8:0] dataCnt_q;
	logic       wideLk_q, endAtOp_q, endAtAddr_q, endAtData_q;
	logic [7:0] pageMem [`FEPC_PAGE_BYTES];
	logic       opRunning_q;

	// frame counters restart whenever select is high
	wire       frameRst  = reset | csLinkN;
	wire [3:0] bitStep   = quadLk_q ? 4'h4 : 4'h1;
	wire [3:0] posSum    = {1'b0, bitPos_q} + bitStep;
	wire       byteDone  = posSum[3];
	wire [7:0] shNext    = quadLk_q ? {shReg_q[3:0], upperIoLines, serialIn}
	                                : {shReg_q[6:0], serialIn};
	wire [3:0] addrBytes = wideLk_q ? 4'h4 : 4'h3;
	wire       opByte    = byteDone && (byteCnt_q == 3'h0);
	wire       addrByte  = byteDone && (byteCnt_q != 3'h0) && ({1'b0, byteCnt_q} <= addrBytes);
	wire       lastAddr  = byteDone && ({1'b0, byteCnt_q} == addrBytes);
	wire       dataByte  = byteDone && ({1'b0, byteCnt_q} > addrBytes);
	wire       memWr     = dataByte && (opcode_q == `FEPC_OP_PAGE) && !busyLk_q;

	// mode and busy levels cross into the link clock
	always_ff @(posedge sclkLink or posedge reset) begin
		if (reset) begin
			quadS1_q <= 1'b0;
			quadLk_q <= 1'b0;
			busyS1_q <= 1'b0;
			busyLk_q <= 1'b0;
		end else begin
			quadS1_q <= quadCmdMode;
			quadLk_q <= quadS1_q;
			busyS1_q <= opRunning_q;
			busyLk_q <= busyS1_q;
		end
	end

	// bit and byte position inside the frame
	always_ff @(posedge sclkLink or posedge frameRst) begin
		if (frameRst) begin
			bitPos_q  <= 3'h0;
			byteCnt_q <= 3'h0;
		end else begin
			bitPos_q <= posSum[2:0];
			if (byteDone && byteCnt_q != 3'h7) begin
				byteCnt_q <= byteCnt_q + 3'h1;
			end
		end
	end

	// frame summary; kept after select rises so the core can read it
	always_ff @(posedge sclkLink or posedge reset) begin
		if (reset) begin
			shReg_q     <= 8'h00;
			opcode_q    <= 8'h00;
			addr_q      <= 32'h0000_0000;
			wideLk_q    <= 1'b0;
			startOff_q  <= 8'h00;
			dataPtr_q   <= 8'h00;
			dataCnt_q   <= 9'h000;
			endAtOp_q   <= 1'b0;
			endAtAddr_q <= 1'b0;
			endAtData_q <= 1'b0;
		end else begin
			shReg_q     <= shNext;
			endAtOp_q   <= opByte;
			endAtAddr_q <= lastAddr;
			endAtData_q <= dataByte;
			if (opByte) begin
				opcode_q  <= shNext;
				dataCnt_q <= 9'h000;
				if (shNext == `FEPC_OP_WIDE_IN) begin
					wideLk_q <= 1'b1;
				end else if (shNext == `FEPC_OP_WIDE_OUT) begin
					wideLk_q <= 1'b0;
				end
			end
			if (addrByte) begin
				addr_q <= {addr_q[23:0], shNext};
			end
			if (lastAddr) begin
				startOff_q <= shNext;
				dataPtr_q  <= shNext;
			end
			if (memWr) begin
				dataPtr_q <= dataPtr_q + 8'h01;
				if (dataCnt_q != 9'h100) begin
					dataCnt_q <= dataCnt_q + 9'h001;
				end
			end
		end
	end

	// page buffer is a ring: later bytes overwrite earlier ones
	always_ff @(posedge sclkLink) begin
		if (memWr) begin
			pageMem[dataPtr_q] <= shNext;
		end
	end

	// ---------------- core domain ----------------
	logic          csS1_q, csS2_q, csS3_q;
	fepc_state_type state_q;
	logic          unlock_q, refused_q, eraseStb_q, pgmStb_q;
	logic [ADDR_W-1:0] eraseBase_q, pgmAddr_q;
	fepc_kind_type eraseKind_q;
	logic [7:0]    pgmData_q, pgmOff_q;
	logic [ADDR_W-9:0] pgmBase_q;
	logic [8:0]    pgmLeft_q;
	logic [31:0]   waitCnt_q;
	logic [BLK_W-1:0] walkBlk_q;

	// block guard lookup under the active scheme
	// guard state comes in as arguments so the wires that call this follow every change
	function automatic logic guardF(input logic [BLK_W-1:0] b, input logic [3:0] s,
		input logic whole, input logic pick, input logic [3:0] bp,
		input logic [NBLK-1:0] pg, input logic [NBLK-1:0] dg, input logic [31:0] eg);
		logic        edgeBlk;
		logic [15:0] secs;
		logic [31:0] fromTop;
		logic        secHit;
		edgeBlk = (b == '0) || (b == BLK_W'(NBLK - 1));
		secs    = (b == '0) ? eg[15:0] : eg[31:16];
		secHit  = whole ? (|secs) : secs[s];
		fromTop = 32'(NBLK - 1) - 32'(b);
		if (pick) begin
			return pg[b] | dg[b] | (edgeBlk & secHit);
		end
		return (bp != 4'h0) && (fromTop < (32'd1 << (bp - 4'h1)));
	endfunction

	// round an address down to its unit
	function automatic logic [ADDR_W-1:0] alignDown(input logic [ADDR_W-1:0] a, input int lsb);
		return a & ~ADDR_W'((64'd1 << lsb) - 64'd1);
	endfunction

	// self-timed length of each kind
	function automatic logic [31:0] timeOf(input fepc_kind_type k);
		case (k)
			FEPC_KIND_SMALL: return SMALL_CYC;
			FEPC_KIND_HALF:  return HALF_CYC;
			FEPC_KIND_FULL:  return FULL_CYC;
			FEPC_KIND_ARRAY: return ARRAY_CYC;
			default:         return PAGE_CYC;
		endcase
	endfunction

	// select rise seen in the core clock; link summary is stable by then
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			csS1_q <= 1'b1;
			csS2_q <= 1'b1;
			csS3_q <= 1'b1;
		end else begin
			csS1_q <= csLinkN;
			csS2_q <= csS1_q;
			csS3_q <= csS2_q;
		end
	end

	// command decode of the finished frame
	wire        frameEnd  = csS2_q & ~csS3_q;
	wire [31:0] addrFull  = wideLk_q ? addr_q
	                        : 32'({highAddrBitsReg, addr_q[23:0]});
	wire [ADDR_W-1:0] cmdAddr = addrFull[ADDR_W-1:0];
	wire [BLK_W-1:0]  cmdBlk  = cmdAddr[ADDR_W-1:16];
	wire [3:0]  cmdSec    = cmdAddr[15:12];
	wire        isSmall   = (opcode_q == `FEPC_OP_SMALL);
	wire        isHalf    = (opcode_q == `FEPC_OP_HALF);
	wire        isFull    = (opcode_q == `FEPC_OP_FULL);
	wire        isArray   = (opcode_q == `FEPC_OP_ARRAY) || (opcode_q == `FEPC_OP_ARRAY_ALT);
	wire        isPage    = (opcode_q == `FEPC_OP_PAGE);
	wire        isWipe    = isSmall | isHalf | isFull;
	wire        goUnlock  = (opcode_q == `FEPC_OP_UNLOCK) && endAtOp_q;
	wire        goWipe    = isWipe && endAtAddr_q && unlock_q
	                        && !guardF(cmdBlk, cmdSec, !isSmall, guardSchemePick, blockGuardBits,
	                        persistentGuardBits, dynamicGuardBits, edgeSectorGuardBits);
	wire        goArray   = isArray && endAtOp_q && unlock_q
	                        && (guardSchemePick || blockGuardBits == 4'h0);
	wire        goPage    = isPage && endAtData_q && unlock_q
	                        && !guardF(cmdBlk, cmdSec, 1'b0, guardSchemePick, blockGuardBits,
	                        persistentGuardBits, dynamicGuardBits, edgeSectorGuardBits);
	wire fepc_kind_type cmdKind = isSmall ? FEPC_KIND_SMALL
	                              : (isHalf ? FEPC_KIND_HALF : FEPC_KIND_FULL);
	wire [ADDR_W-1:0] wipeBase = alignDown(cmdAddr, isSmall ? `FEPC_SMALL_LSB
	                              : (isHalf ? `FEPC_HALF_LSB : `FEPC_FULL_LSB));
	wire        walkSkip  = guardF(walkBlk_q, 4'h0, 1'b1, guardSchemePick, blockGuardBits,
	                        persistentGuardBits, dynamicGuardBits, edgeSectorGuardBits);

	// sequencer; rejected frames fall through with no state change
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q     <= FEPC_ST_IDLE;
			opRunning_q <= 1'b0;
			unlock_q    <= 1'b0;
			refused_q   <= 1'b0;
			eraseStb_q  <= 1'b0;
			eraseBase_q <= '0;
			eraseKind_q <= FEPC_KIND_SMALL;
			pgmStb_q    <= 1'b0;
			pgmAddr_q   <= '0;
			pgmData_q   <= 8'h00;
			pgmBase_q   <= '0;
			pgmOff_q    <= 8'h00;
			pgmLeft_q   <= 9'h000;
			waitCnt_q   <= 32'h0000_0000;
			walkBlk_q   <= '0;
		end else begin
			eraseStb_q <= 1'b0;
			pgmStb_q   <= 1'b0;
			refused_q  <= 1'b0;
			case (state_q)
				FEPC_ST_IDLE: begin
					if (frameEnd && goUnlock) begin
						unlock_q <= 1'b1;
					end
					if (frameEnd && goWipe) begin
						eraseStb_q  <= 1'b1;
						eraseBase_q <= wipeBase;
						eraseKind_q <= cmdKind;
						waitCnt_q   <= timeOf(cmdKind);
						opRunning_q <= 1'b1;
						state_q     <= FEPC_ST_WAIT;
					end else if (frameEnd && goArray) begin
						opRunning_q <= 1'b1;
						waitCnt_q   <= ARRAY_CYC;
						walkBlk_q   <= '0;
						if (guardSchemePick) begin
							state_q <= FEPC_ST_WALK_CHIP;
						end else begin
							eraseStb_q  <= 1'b1;
							eraseBase_q <= '0;
							eraseKind_q <= FEPC_KIND_ARRAY;
							state_q     <= FEPC_ST_WAIT;
						end
					end else if (frameEnd && goPage) begin
						opRunning_q <= 1'b1;
						waitCnt_q   <= PAGE_CYC;
						pgmBase_q   <= cmdAddr[ADDR_W-1:8];
						pgmOff_q    <= startOff_q;
						pgmLeft_q   <= dataCnt_q;
						state_q     <= FEPC_ST_WALK_PAGE;
					end else if (frameEnd && (isWipe || isArray || isPage)) begin
						refused_q <= 1'b1;
					end
				end
				FEPC_ST_WALK_CHIP: begin
					// guarded blocks get no strobe at all
					if (!walkSkip) begin
						eraseStb_q  <= 1'b1;
						eraseBase_q <= {walkBlk_q, 16'h0000};
						eraseKind_q <= FEPC_KIND_FULL;
					end
					walkBlk_q <= walkBlk_q + 1'b1;
					if (walkBlk_q == BLK_W'(NBLK - 1)) begin
						state_q <= FEPC_ST_WAIT;
					end
				end
				FEPC_ST_WALK_PAGE: begin
					pgmStb_q  <= 1'b1;
					pgmAddr_q <= {pgmBase_q, pgmOff_q};
					pgmData_q <= pageMem[pgmOff_q];
					pgmOff_q  <= pgmOff_q + 8'h01;
					pgmLeft_q <= pgmLeft_q - 9'h001;
					if (pgmLeft_q <= 9'h001) begin
						state_q <= FEPC_ST_WAIT;
					end
				end
				FEPC_ST_WAIT: begin
					// flag stays up for the whole count so polling sees it
					if (waitCnt_q <= 32'h0000_0001) begin
						opRunning_q <= 1'b0;
						unlock_q    <= 1'b0;
						state_q     <= FEPC_ST_IDLE;
					end else begin
						waitCnt_q <= waitCnt_q - 32'h0000_0001;
					end
				end
				default: begin
					state_q <= FEPC_ST_IDLE;
				end
			endcase
		end
	end

	assign opRunningFlag   = opRunning_q;
	assign writeUnlockFlag = unlock_q;
	assign cmdRefused      = refused_q;
	assign arrEraseStb     = eraseStb_q;
	assign arrEraseBase    = eraseBase_q;
	assign arrEraseKind    = eraseKind_q;
	assign arrPgmStb       = pgmStb_q;
	assign arrPgmAddr      = pgmAddr_q;
	assign arrPgmData      = pgmData_q;

	// ---------------- checks ----------------
	logic [9:0] pgmSeen_q;

	// counts program strobes of the current operation
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pgmSeen_q <= 10'h000;
		end else if (state_q == FEPC_ST_IDLE) begin
			pgmSeen_q <= 10'h000;
		end else if (pgmStb_q) begin
			pgmSeen_q <= pgmSeen_q + 10'h001;
		end
	end

	default clocking cbCore @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_unlock_first;
		$rose(opRunning_q) |-> $past(unlock_q);
	endproperty
	a_unlock_first: assert property (p_unlock_first) else $error("run without unlock");

	property p_start_frame;
		$rose(opRunning_q) |-> $past(frameEnd);
	endproperty
	a_start_frame: assert property (p_start_frame) else $error("run not at select rise");

	property p_end_clears;
		$fell(opRunning_q) |-> !unlock_q && state_q == FEPC_ST_IDLE;
	endproperty
	a_end_clears: assert property (p_end_clears) else $error("unlock kept after cycle");

	property p_small_base;
		eraseStb_q && eraseKind_q == FEPC_KIND_SMALL |-> eraseBase_q[11:0] == 12'h000;
	endproperty
	a_small_base: assert property (p_small_base) else $error("sector base unaligned");

	property p_half_base;
		eraseStb_q && eraseKind_q == FEPC_KIND_HALF |-> eraseBase_q[14:0] == 15'h0000;
	endproperty
	a_half_base: assert property (p_half_base) else $error("half block unaligned");

	property p_busy_holds;
		opRunning_q && waitCnt_q > 32'h0000_0001 |=> opRunning_q;
	endproperty
	a_busy_holds: assert property (p_busy_holds) else $error("running flag dropped early");

	property p_page_bound;
		pgmStb_q |-> pgmAddr_q[ADDR_W-1:8] == pgmBase_q && pgmSeen_q < 10'h100;
	endproperty
	a_page_bound: assert property (p_page_bound) else $error("page write left page");

	property p_refuse;
		frameEnd && state_q == FEPC_ST_IDLE && !unlock_q |=> !opRunning_q[*2];
	endproperty
	a_refuse: assert property (p_refuse) else $error("locked command ran");

	property p_array_guard;
		$rose(opRunning_q) && $past(isArray) && !$past(guardSchemePick)
			|-> $past(blockGuardBits) == 4'h0;
	endproperty
	a_array_guard: assert property (p_array_guard) else $error("array wipe with guards");

	property p_walk_skip;
		$past(state_q) == FEPC_ST_WALK_CHIP && eraseStb_q |-> !$past(walkSkip);
	endproperty
	a_walk_skip: assert property (p_walk_skip) else $error("guarded block wiped");

	c_small: cover property (eraseStb_q && eraseKind_q == FEPC_KIND_SMALL);
	c_page:  cover property (pgmStb_q ##1 state_q == FEPC_ST_WAIT);
	c_walk:  cover property (state_q == FEPC_ST_WALK_CHIP && walkSkip);
	c_deny:  cover property (refused_q);

endmodule // fepc_flash_seq

// >>> dv/fepc_host_model.sv
// fepc_host_model.sv: behavioural host that frames commands on the serial link
// assumes the bench calls frame() between frames and holds quadCmdMode for a whole frame
`timescale 1ns/10ps
module fepc_host_model (
	output logic       sclkLink,
	output logic       csLinkN,
	output logic       serialIn,
	output logic [2:0] upperIoLines,
	input  wire logic  quadCmdMode
);
	// link idle: clock parked low, select high
	initial begin
		sclkLink = 1'b0;
		csLinkN = 1'b1;
		serialIn = 1'b0;
		upperIoLines = 3'h0;
	end

	// opcode, address, data in one select-low frame; extra clocks break the byte boundary
	task automatic frame(input logic [7:0] b[$], input int extra);
		int w;
		int k;
		logic [7:0] cur;
		w = quadCmdMode ? 4 : 1;
		// two idle clocks with select high let mode and busy cross into the link domain
		repeat (2) begin
			#62.5 sclkLink = 1'b1;
			#62.5 sclkLink = 1'b0;
		end
		csLinkN = 1'b0;
		for (k = 0; k < b.size() * 8 / w + extra; k++) begin
			cur = (k * w / 8 < b.size()) ? b[k * w / 8] : 8'h5A;
			if (quadCmdMode) begin
				{upperIoLines, serialIn} = (k % 2 == 0) ? cur[7:4] : cur[3:0];
			end else begin
				serialIn = cur[7 - k % 8];
				upperIoLines = ~cur[2:0]; // junk on unused lines
			end
			#62.5 sclkLink = 1'b1;
			#62.5 sclkLink = 0;
		end
		// release right after the last bit, then stop holding old data
		#62.5 csLinkN = 1'b1;
		serialIn = ~serialIn;
		upperIoLines = ~upperIoLines;
	endtask
endmodule // fepc_host_model

// >>> dv/fepc_flash_seq_test.sv
// fepc_flash_seq_test.sv: self-checking bench for the erase/program sequencer
// assumes the host model drives the link; array strobes are judged against a note queue
`timescale 1ns/10ps
module fepc_flash_seq_test;
	import fepc_pkg::*;
	localparam logic [38:0] REFUSE = {2'h3, 37'h0};
	logic            core_clk = 1'b0;
	logic            reset = 1'b1;
	logic            quadCmdMode = 1'b0;
	logic            guardSchemePick = 1'b0;
	logic [3:0]      blockGuardBits = 4'h0;
	logic [1023:0]   persistentGuardBits = 1024'h0;
	logic [1023:0]   dynamicGuardBits = 1024'h0;
	logic [31:0]     edgeSectorGuardBits = 32'h0;
	logic [1:0]      highAddrBitsReg = 2'h0;
	wire logic       sclkLink, csLinkN, serialIn;
	wire logic [2:0] upperIoLines;
	logic            opRunningFlag, writeUnlockFlag, cmdRefused, arrEraseStb, arrPgmStb;
	fepc_kind_type   arrEraseKind;
	logic [25:0]     arrEraseBase, arrPgmAddr;
	logic [7:0]      arrPgmData;
	logic [38:0]     notes[$];
	logic [7:0]      nob[$];
	logic [7:0]      ops[3] = '{8'h20, 8'h52, 8'hD8};
	int              lsb[3] = '{12, 15, 16};
	logic [31:0]     seed = 32'h142B7;
	int              errors = 0;
	int              n_checks = 0;

	always #10 core_clk = ~core_clk;

	// short cycle counts keep the run small
	fepc_flash_seq #(.SMALL_CYC(32'h28), .HALF_CYC(32'h32), .FULL_CYC(32'h3C),
		.ARRAY_CYC(32'h50), .PAGE_CYC(32'h1E)) uut (
		.core_clk, .reset, .sclkLink, .csLinkN, .serialIn, .upperIoLines, .quadCmdMode,
		.guardSchemePick, .blockGuardBits, .persistentGuardBits, .dynamicGuardBits,
		.edgeSectorGuardBits, .highAddrBitsReg, .opRunningFlag, .writeUnlockFlag, .cmdRefused,
		.arrEraseStb, .arrEraseBase, .arrEraseKind, .arrPgmStb, .arrPgmAddr, .arrPgmData);
	fepc_host_model host (.sclkLink, .csLinkN, .serialIn, .upperIoLines, .quadCmdMode);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [38:0] er(input logic [2:0] k, input logic [25:0] base);
		return {2'h1, k, base, 8'h00};
	endfunction

	task automatic chk(input string nm, input logic [38:0] exp, input logic [38:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// frame a command, then see the cycle run out and, for a command that runs, the unlock drop
	task automatic cmd(input logic [7:0] op, input int na, input logic [31:0] a,
		input logic [7:0] d[$], input int extra, input logic run);
		logic [7:0] b[$];
		int k;
		b = {op};
		for (k = na - 1; k >= 0; k--) b.push_back(a[8 * k +: 8]);
		b = {b, d};
		host.frame(b, extra);
		repeat (8) @(negedge core_clk);
		chk("running", 39'(run), 39'(opRunningFlag));
		for (k = 0; k < 3000 && opRunningFlag !== 1'b0; k++) @(negedge core_clk);
		chk("done", 39'h0, 39'(opRunningFlag));
		if (run) chk("unlock", 39'h0, 39'(writeUnlockFlag));
	endtask

	task automatic unlock();
		cmd(8'h06, 0, 0, nob, 0, 0);
		chk("unlock", 39'h1, 39'(writeUnlockFlag));
	endtask

	// oldest note against every strobe or refusal pulse, sampled mid-cycle
	task automatic see(input logic [38:0] v);
		if (notes.size() == 0) chk("unplanned", 39'h0, v);
		else chk("result", notes.pop_front(), v);
	endtask
	always @(negedge core_clk) begin
		if (arrEraseStb === 1'b1) see(er(3'(arrEraseKind), arrEraseBase));
		if (arrPgmStb === 1'b1) see({2'h2, 3'h0, arrPgmAddr, arrPgmData});
		if (cmdRefused === 1'b1) see(REFUSE);
	end

	task automatic print_verdict();
		chk("pending", 39'h0, 39'(notes.size()));
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// cut a hang well past the expected run length
	initial begin
		#1800000;
		errors++;
		print_verdict();
	end

	initial begin
		logic [31:0] a;
		logic [7:0] d[$];
		int i;
		int k;
		repeat (3) @(negedge core_clk);
		chk("reset", 39'h0, 39'({opRunningFlag, writeUnlockFlag, cmdRefused, arrEraseStb,
			arrPgmStb}));
		reset = 1'b0;
		a = rnd();
		highAddrBitsReg = a[1:0];
		repeat (3) @(negedge core_clk);
		notes.push_back(REFUSE);
		cmd(8'h20, 3, rnd(), nob, 0, 0);
		// each wipe size at a random address inside its unit
		for (i = 0; i < 3; i++) begin
			unlock();
			a = rnd();
			notes.push_back(er(3'(i), 26'({highAddrBitsReg, a[23:0]} >> lsb[i] << lsb[i])));
			cmd(ops[i], 3, a, nob, 0, 1);
		end
		// select released one bit early or late
		unlock();
		for (i = -1; i < 2; i += 2) begin
			notes.push_back(REFUSE);
			cmd(8'hD8, 3, rnd(), nob, i, 0);
		end
		chk("unlock", 39'h1, 39'(writeUnlockFlag));
		// top block guarded by region bits
		highAddrBitsReg = 2'h3;
		blockGuardBits = 4'h1;
		d = '{8'h3C};
		notes.push_back(REFUSE);
		cmd(8'h52, 3, 32'hFF8000, nob, 0, 0);
		notes.push_back(REFUSE);
		cmd(8'h60, 0, 0, nob, 0, 0);
		notes.push_back(REFUSE);
		cmd(8'h02, 3, 32'hFF0000, d, 0, 0);
		// per-block guards, edge sector guard in the top block
		blockGuardBits = 4'h0;
		highAddrBitsReg = 2'h0;
		guardSchemePick = 1'b1;
		persistentGuardBits[5] = 1'b1;
		dynamicGuardBits[7] = 1'b1;
		edgeSectorGuardBits[20] = 1'b1;
		notes.push_back(REFUSE);
		cmd(8'h20, 3, 32'h053000, nob, 0, 0);
		notes.push_back(REFUSE);
		cmd(8'h02, 3, 32'h070100, d, 0, 0);
		for (k = 0; k < 1023; k++) if (k != 5 && k != 7) notes.push_back(er(3'h2, 26'(k) << 16));
		cmd(8'hC7, 0, 0, nob, 0, 1);
		guardSchemePick = 1'b0;
		unlock();
		notes.push_back(REFUSE);
		cmd(8'h60, 0, 0, nob, 1, 0);
		for (i = 0; i < 2; i++) begin
			unlock();
			notes.push_back(er(3'h3, 26'h0));
			cmd(i ? 8'hC7 : 8'h60, 0, 0, nob, 0, 1);
		end
		// page write near the page end wraps round
		unlock();
		a = rnd();
		a[7:0] = 8'hFE;
		d = {};
		for (k = 0; k < 4; k++) d.push_back(8'(rnd()));
		for (k = 0; k < 4; k++) notes.push_back({2'h2, 3'h0, 2'h0, a[23:8], 8'(8'hFE + k), d[k]});
		cmd(8'h02, 3, a, d, 0, 1);
		// 258 bytes: the first two are overwritten
		unlock();
		a[7:0] = 8'h00;
		d = {};
		for (k = 0; k < 258; k++) d.push_back(8'(rnd()));
		for (k = 0; k < 256; k++)
			notes.push_back({2'h2, 3'h0, 2'h0, a[23:8], 8'(k), d[k < 2 ? k + 256 : k]});
		cmd(8'h02, 3, a, d, 0, 1);
		// page frames off the byte boundary or with no data
		unlock();
		notes.push_back(REFUSE);
		cmd(8'h02, 3, a, d[0:1], 1, 0);
		notes.push_back(REFUSE);
		cmd(8'h02, 3, a, nob, 0, 0);
		// four-line opcodes and addresses
		quadCmdMode = 1'b1;
		unlock();
		notes.push_back(er(3'h0, {2'h0, a[23:12], 12'h000}));
		cmd(8'h20, 3, a, nob, 0, 1);
		quadCmdMode = 1'b0;
		// wide addresses replace the high address bits
		cmd(8'hB7, 0, 0, nob, 0, 0);
		unlock();
		a = rnd();
		notes.push_back(er(3'h1, {a[25:15], 15'h0000}));
		cmd(8'h52, 4, a, nob, 0, 1);
		cmd(8'hE9, 0, 0, nob, 0, 0);
		repeat (4) @(negedge core_clk);
		print_verdict();
	end
endmodule // fepc_flash_seq_test
